// [drs_cfg.svh]
// register map, field positions, reset values and codes of the reference selector
// assumes a 32-bit apb bus with a 12-bit byte address
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH
`define DRS_A_CTRL 12'h000
`define DRS_A_PRIO 12'h004
`define DRS_A_BUF 12'h008
`define DRS_A_RATE 12'h00c
`define DRS_A_SLEW 12'h010
`define DRS_A_STAT 12'h014
`define DRS_A_PHASE 12'h018
`define DRS_A_IST 12'h01c
`define DRS_A_IEN 12'h020
`define DRS_A_ICLR 12'h024
`define DRS_C_MODE 1:0
`define DRS_C_MAN 3:2
`define DRS_C_PIN 4
`define DRS_C_CANCEL 5
`define DRS_C_SLEW 6
`define DRS_CTRL_RST 7'h00
`define DRS_PRIO_RST 8'he4
`define DRS_BUF_RST 20'h00000
`define DRS_RATE_RST 32'h01010101
`define DRS_SLIM_RST 16'h0001
`define DRS_STIM_RST 16'h0000
`define DRS_EV_SWITCH 0
`define DRS_EV_HOLD 1
`define DRS_EV_FREE 2
`define DRS_EV_BADTYPE 3
`define DRS_BT_DC 5'h00
`define DRS_BT_AC 5'h01
`define DRS_BT_DC100 5'h02
`define DRS_BT_AC100 5'h03
`define DRS_BT_SE50 5'h04
`define DRS_BT_SE50B 5'h05
`define DRS_BT_CMOS 5'h08
`define DRS_BT_CMOSDC 5'h18
`define DRS_BT_CMOSDC50 5'h1c
`endif

// [drs_pkg.sv]
// types of the reference selector
// assumes drs_cfg.svh is compiled alongside
`default_nettype none
package drs_pkg;
  typedef enum logic [1:0] {
    ST_FREE = 2'b00,
    ST_LOCK = 2'b01,
    ST_HOLD = 2'b10
  } drs_fsm_t;
  typedef enum logic [1:0] {
    MD_AUTO_REV = 2'b00,
    MD_AUTO_NREV = 2'b01,
    MD_MAN_FB = 2'b10,
    MD_MAN_HO = 2'b11
  } drs_mode_t;
  typedef struct packed {
    logic [6:0] ctrl_ff;
    logic [7:0] prio_ff;
    logic [19:0] buf_ff;
    logic [31:0] rate_ff;
    logic [15:0] slim_ff;
    logic [15:0] stim_ff;
    logic [3:0] ien_ff;
    logic [3:0] ist_ff;
    drs_fsm_t st_ff;
    logic [1:0] act_ff;
    logic [15:0] bo_ff;
    logic [15:0] pout_ff;
    logic [15:0] tcnt_ff;
    logic [19:0] sw_ff;
    logic [1:0] g1_ff;
    logic [1:0] g2_ff;
    logic [1:0] g3_ff;
    logic [1:0] gsel_ff;
    logic [31:0] rdata_ff;
    logic slverr_ff;
  } drs_state_t;
endpackage : drs_pkg
`default_nettype wire

// [drs_ref_select.sv]
// reference input selection, buffer switch decoding and hitless phase control
// assumes monitors' valid flags and phase words come on core_clk; gpio select is async
`default_nettype none
`include "drs_cfg.svh"
module drs_ref_select import drs_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // monitors and loop
  input wire logic [3:0] ref_valid,
  input wire logic [63:0] ref_phase,
  input wire logic tw_history_valid,
  input wire logic [1:0] gpio_ref_sel,
  // selection and phase
  output logic [3:0] ref_mux_sel,
  output logic [1:0] active_ref,
  output logic holdover,
  output logic free_run,
  output logic [15:0] phase_target,
  output logic [15:0] phase_buildout,
  // buffer switches per input
  output logic [3:0] se_term_50,
  output logic [3:0] diff_term_100,
  output logic [3:0] bias_1v3,
  output logic [3:0] ac_cap_bypass_switch,
  output logic [3:0] amp_det_en,
  // interrupt
  output logic irq
);
  drs_state_t s, n;
  logic [3:0] ev;
  logic [19:0] dec;
  logic [3:0] bad;
  logic any;
  logic [1:0] best;
  logic [1:0] bp;
  logic [1:0] man;
  logic [1:0] tgt;
  logic go;
  logic sw;
  logic fl;
  logic [15:0] step;
  logic [15:0] mag;
  logic [15:0] dec_amt;
  logic [3:0] evt;
  logic wr;
  drs_mode_t mode;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      logic [4:0] code;
      logic [4:0] o;
      logic u;
      assign code = s.buf_ff[5*gi +: 5];
      // a zero rate code means the pre-divider cannot reach the common rate
      assign ev[gi] = ref_valid[gi] & (s.rate_ff[8*gi +: 8] != 8'h00);
      always_comb begin
        o = 5'h00;
        u = 1'b0;
        // o: {amp, bypass, bias, diff100, se50}
        case (code)
          `DRS_BT_DC: o = 5'h10;
          `DRS_BT_AC: o = 5'h14;
          `DRS_BT_DC100: o = 5'h12;
          `DRS_BT_AC100: o = 5'h16;
          `DRS_BT_SE50: o = 5'h11;
          `DRS_BT_SE50B: o = 5'h15;
          `DRS_BT_CMOS: o = 5'h00;
          `DRS_BT_CMOSDC: o = 5'h08;
          `DRS_BT_CMOSDC50: o = 5'h09;
          default: u = 1'b1;
        endcase
      end
      assign dec[5*gi +: 5] = o;
      assign bad[gi] = u;
      assign se_term_50[gi] = s.sw_ff[5*gi];
      assign diff_term_100[gi] = s.sw_ff[5*gi+1];
      assign bias_1v3[gi] = s.sw_ff[5*gi+2];
      assign ac_cap_bypass_switch[gi] = s.sw_ff[5*gi+3];
      assign amp_det_en[gi] = s.sw_ff[5*gi+4];
    end
  endgenerate

  assign mode = drs_mode_t'(s.ctrl_ff[`DRS_C_MODE]);
  assign man = s.ctrl_ff[`DRS_C_PIN] ? s.gsel_ff : s.ctrl_ff[`DRS_C_MAN];
  assign wr = psel & penable & pwrite;

  // priority search: lower value wins, ties go to the lower index
  always_comb begin
    any = 1'b0;
    best = 2'b00;
    bp = 2'b11;
    for (int i = 3; i >= 0; i--) begin
      if (ev[i] && (!any || s.prio_ff[2*i +: 2] <= bp)) begin
        any = 1'b1;
        best = 2'(i);
        bp = s.prio_ff[2*i +: 2];
      end
    end
  end

  always_comb begin
    go = 1'b0;
    tgt = s.act_ff;
    case (mode)
      MD_AUTO_REV: begin
        go = any;
        tgt = best;
      end
      MD_AUTO_NREV: begin
        if (s.st_ff == ST_LOCK && ev[s.act_ff]) begin
          go = 1'b1;
        end else begin
          go = any;
          tgt = best;
        end
      end
      MD_MAN_FB: begin
        if (ev[man]) begin
          go = 1'b1;
          tgt = man;
        end else begin
          go = any;
          tgt = best;
        end
      end
      MD_MAN_HO: begin
        go = ev[man];
        tgt = man;
      end
      default: go = 1'b0;
    endcase
  end

  assign sw = go && (s.st_ff != ST_LOCK || tgt != s.act_ff);
  // while locked, the same nonzero divided rate on both sides counts as frequency-locked
  assign fl = s.st_ff == ST_LOCK && s.rate_ff[8*tgt +: 8] == s.rate_ff[8*s.act_ff +: 8];
  assign step = ref_phase[16*tgt +: 16] - s.pout_ff;
  assign mag = s.bo_ff[15] ? 16'(-s.bo_ff) : s.bo_ff;
  assign dec_amt = mag < s.slim_ff ? mag : s.slim_ff;

  always_comb begin
    n = s;
    evt = 4'h0;
    // three-stage sync; the first stage feeds only the second
    n.g1_ff = gpio_ref_sel;
    n.g2_ff = s.g1_ff;
    n.g3_ff = s.g2_ff;
    if (s.g2_ff == s.g3_ff) begin
      n.gsel_ff = s.g3_ff;
    end
    n.sw_ff = dec;
    evt[`DRS_EV_BADTYPE] = |bad;
    if (go) begin
      n.st_ff = ST_LOCK;
      n.act_ff = tgt;
    end else if (tw_history_valid) begin
      n.st_ff = ST_HOLD;
      evt[`DRS_EV_HOLD] = s.st_ff != ST_HOLD;
    end else begin
      n.st_ff = ST_FREE;
      evt[`DRS_EV_FREE] = s.st_ff != ST_FREE;
    end
    if (sw) begin
      evt[`DRS_EV_SWITCH] = 1'b1;
      n.tcnt_ff = 16'h0000;
      if (fl) begin
        // absorb the offset so the output does not jump
        n.bo_ff = s.ctrl_ff[`DRS_C_CANCEL] | s.ctrl_ff[`DRS_C_SLEW] ? step : 16'h0000;
      end else begin
        // holdover exit or unlocked switch: only slew smooths it
        n.bo_ff = s.ctrl_ff[`DRS_C_SLEW] ? step : 16'h0000;
      end
    end else if (s.st_ff == ST_LOCK && s.ctrl_ff[`DRS_C_SLEW] && s.bo_ff != 16'h0000) begin
      if (s.tcnt_ff >= s.stim_ff) begin
        n.tcnt_ff = 16'h0000;
        n.bo_ff = s.bo_ff[15] ? s.bo_ff + dec_amt : s.bo_ff - dec_amt;
      end else begin
        n.tcnt_ff = s.tcnt_ff + 16'h0001;
      end
    end
    // with both off the raw step reaches the loop filter, which sets the rate
    if (go) begin
      n.pout_ff = ref_phase[16*tgt +: 16] - n.bo_ff;
    end
    // apb: registers captured in setup, access completes at once
    if (psel && !penable) begin
      n.slverr_ff = 1'b0;
      case (paddr)
        `DRS_A_CTRL: n.rdata_ff = {25'h0, s.ctrl_ff};
        `DRS_A_PRIO: n.rdata_ff = {24'h0, s.prio_ff};
        `DRS_A_BUF: n.rdata_ff = {12'h0, s.buf_ff};
        `DRS_A_RATE: n.rdata_ff = s.rate_ff;
        `DRS_A_SLEW: n.rdata_ff = {s.stim_ff, s.slim_ff};
        `DRS_A_STAT: n.rdata_ff = {24'h0, ref_valid, s.st_ff, s.act_ff};
        `DRS_A_PHASE: n.rdata_ff = {s.bo_ff, s.pout_ff};
        `DRS_A_IST: n.rdata_ff = {28'h0, s.ist_ff};
        `DRS_A_IEN: n.rdata_ff = {28'h0, s.ien_ff};
        `DRS_A_ICLR: n.rdata_ff = 32'h0;
        default: begin
          n.rdata_ff = 32'h0;
          n.slverr_ff = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        `DRS_A_CTRL: n.ctrl_ff = pwdata[6:0];
        `DRS_A_PRIO: n.prio_ff = pwdata[7:0];
        `DRS_A_BUF: n.buf_ff = pwdata[19:0];
        `DRS_A_RATE: n.rate_ff = pwdata;
        `DRS_A_SLEW: begin
          n.slim_ff = pwdata[15:0];
          n.stim_ff = pwdata[31:16];
        end
        `DRS_A_IEN: n.ien_ff = pwdata[3:0];
        default: n.ctrl_ff = s.ctrl_ff;
      endcase
    end
    // a clear loses to an event in the same cycle
    n.ist_ff = (s.ist_ff & ~((wr && paddr == `DRS_A_ICLR) ? pwdata[3:0] : 4'h0)) | evt;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.ctrl_ff <= `DRS_CTRL_RST;
      s.prio_ff <= `DRS_PRIO_RST;
      s.buf_ff <= `DRS_BUF_RST;
      s.rate_ff <= `DRS_RATE_RST;
      s.slim_ff <= `DRS_SLIM_RST;
      s.stim_ff <= `DRS_STIM_RST;
      s.st_ff <= ST_FREE;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.rdata_ff;
  assign pslverr = s.slverr_ff;
  assign pready = 1'b1;
  assign ref_mux_sel = (s.st_ff == ST_LOCK) ? (4'h1 << s.act_ff) : 4'h0;
  assign active_ref = s.act_ff;
  assign holdover = s.st_ff == ST_HOLD;
  assign free_run = s.st_ff == ST_FREE;
  assign phase_target = s.pout_ff;
  assign phase_buildout = s.bo_ff;
  assign irq = |(s.ist_ff & s.ien_ff);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_rev_best: assert property (mode == MD_AUTO_REV && any && !wr |=>
    s.st_ff == ST_LOCK && s.act_ff == $past(best)) else $error("revertive pick wrong");
  a_nrev_keep: assert property (mode == MD_AUTO_NREV && s.st_ff == ST_LOCK
    && ev[s.act_ff] && !wr |=> $stable(s.act_ff)) else $error("non-revertive moved");
  a_man_use: assert property (mode[1] && ev[man] && !wr |=>
    s.act_ff == $past(man) && s.st_ff == ST_LOCK) else $error("manual ref unused");
  a_man_fall: assert property (mode == MD_MAN_FB && !ev[man] && any && !wr |=>
    s.act_ff == $past(best)) else $error("fallback wrong");
  a_man_hold: assert property (mode == MD_MAN_HO && !ev[man] && tw_history_valid
    && !wr |=> s.st_ff == ST_HOLD) else $error("no holdover");
  a_free_run: assert property (!go && !tw_history_valid |=> free_run)
    else $error("no free-run");
  a_buf_ac100: assert property (s.buf_ff[4:0] == `DRS_BT_AC100 |=>
    diff_term_100[0] && bias_1v3[0] && !se_term_50[0]) else $error("code 3 wrong");
  a_amp_det: assert property (!s.buf_ff[8] && !bad[1] |=>
    amp_det_en[1] && !ac_cap_bypass_switch[1]) else $error("amp detector off");
  a_bo_keep: assert property (s.st_ff == ST_LOCK && !s.ctrl_ff[`DRS_C_SLEW]
    && !sw && !wr |=> $stable(s.bo_ff)) else $error("buildout drifted");
  a_bo_none: assert property (sw && s.ctrl_ff[6:5] == 2'b00 && !wr |=>
    s.bo_ff == 16'h0000 ##0 s.pout_ff == $past(ref_phase[16*tgt +: 16]))
    else $error("step not passed");
  a_elig: assert property (go |-> ref_valid[tgt] && s.rate_ff[8*tgt +: 8] != 8'h00)
    else $error("ineligible active");
  a_hold_exit: assert property (mode[1] && s.st_ff == ST_HOLD && ev[man] |=>
    s.st_ff == ST_LOCK && s.act_ff == $past(man))
    else $error("holdover not left");
  a_ho_nofall: assert property (mode == MD_MAN_HO && !ev[man] |=>
    s.st_ff != ST_LOCK)
    else $error("manual holdover fell back");
  a_nrev_fail: assert property (mode == MD_AUTO_NREV && s.st_ff == ST_LOCK && any
    && !ev[s.act_ff] |=> s.st_ff == ST_LOCK && s.act_ff == $past(best))
    else $error("non-revertive did not move");
  a_no_lock: assert property (!go |=>
    s.st_ff != ST_LOCK && ref_mux_sel == 4'h0)
    else $error("locked without a reference");
  a_pin_use: assert property (s.ctrl_ff[`DRS_C_PIN] && mode[1] && ev[s.gsel_ff] |=>
    s.act_ff == $past(s.gsel_ff))
    else $error("pin choice unused");
  a_sync_agree: assert property (s.g2_ff != s.g3_ff |=>
    $stable(s.gsel_ff))
    else $error("pin choice taken unsettled");
  // phase target must not jump when the offset is absorbed
  a_cancel: assert property (sw && fl && s.ctrl_ff[`DRS_C_CANCEL] |=>
    s.bo_ff == $past(step) && $stable(s.pout_ff))
    else $error("offset not absorbed");
  a_slew_exit: assert property (sw && !fl && s.ctrl_ff[`DRS_C_SLEW] |=>
    s.bo_ff == $past(step))
    else $error("unlocked switch not slewed");
  a_step_pass: assert property (sw && !s.ctrl_ff[`DRS_C_SLEW]
    && !(fl && s.ctrl_ff[`DRS_C_CANCEL]) |=> s.bo_ff == 16'h0000)
    else $error("phase step held back");
  // slew bounds: one step per timer expiry, never past zero
  a_slew_step: assert property (s.st_ff == ST_LOCK && s.ctrl_ff[`DRS_C_SLEW] && !sw
    && s.bo_ff != 16'h0000 && s.tcnt_ff >= s.stim_ff |=> mag <= $past(mag)
    && $past(mag) - mag <= $past(s.slim_ff)) else $error("slew step too large");
  a_slew_wait: assert property (s.st_ff == ST_LOCK && !sw && s.tcnt_ff < s.stim_ff |=>
    $stable(s.bo_ff))
    else $error("slew stepped early");
  // switch outputs lag the stored code by one register, hence next-cycle checks
  a_cmos_off: assert property (s.buf_ff[9:5] == `DRS_BT_CMOS |=>
    !(se_term_50[1] | diff_term_100[1] | bias_1v3[1] | ac_cap_bypass_switch[1] | amp_det_en[1]))
    else $error("lvcmos switches on");
  a_se50_term: assert property (s.buf_ff[19:15] == `DRS_BT_SE50B |=>
    se_term_50[3] && bias_1v3[3] && !diff_term_100[3])
    else $error("code 5 wrong");
  a_dc_bypass: assert property (s.buf_ff[14:10] == `DRS_BT_CMOSDC50 |=>
    ac_cap_bypass_switch[2] && se_term_50[2] && !amp_det_en[2])
    else $error("bypass code wrong");
  // a clear in the same cycle as an event must not lose it
  a_set_wins: assert property (evt != 4'h0 |=>
    (s.ist_ff & $past(evt)) == $past(evt))
    else $error("event lost");
  a_bad_flag: assert property (|bad |=>
    s.ist_ff[`DRS_EV_BADTYPE])
    else $error("bad code not flagged");
  a_switch_evt: assert property (sw |=>
    s.ist_ff[`DRS_EV_SWITCH])
    else $error("switch not flagged");
  a_hold_event: assert property (s.st_ff != ST_HOLD && !go && tw_history_valid |=>
    holdover && s.ist_ff[`DRS_EV_HOLD])
    else $error("holdover entry not flagged");
  a_free_event: assert property (s.st_ff != ST_FREE && !go && !tw_history_valid |=>
    free_run && s.ist_ff[`DRS_EV_FREE])
    else $error("free-run entry not flagged");
  c_switch: cover property (sw && fl ##1 s.bo_ff != 16'h0000);
  c_hold: cover property (s.st_ff == ST_LOCK ##1 s.st_ff == ST_HOLD);
  c_bleed: cover property (s.bo_ff != 16'h0000 ##[1:50] s.bo_ff == 16'h0000);
  c_pin_lock: cover property (s.ctrl_ff[`DRS_C_PIN] && s.st_ff == ST_LOCK
    && s.act_ff == s.gsel_ff);
  c_nrev_fall: cover property (mode == MD_AUTO_NREV && sw);
endmodule : drs_ref_select
`default_nettype wire

// [drs_ref_src.sv]
// monitor-side model of the reference selector: qualified flags, phase words, pins
// assumes the bench commands it just after rising edges of core_clk
`default_nettype none
module drs_ref_src (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // bench commands
  input wire logic [3:0] want_valid,
  input wire logic want_hist,
  input wire logic [1:0] want_pin,
  // monitor side
  output logic [3:0] ref_valid,
  output logic [63:0] ref_phase,
  output logic tw_history_valid,
  output logic [1:0] gpio_ref_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  // flags come out of monitors clocked on core_clk, so one cycle behind the command
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ref_valid <= 4'h0;
      tw_history_valid <= 1'b0;
    end else begin
      ref_valid <= want_valid;
      tw_history_valid <= want_hist;
    end
  end
  // fixed offsets keep every expected buildout exact; inputs are frequency-locked
  assign ref_phase = {16'h0c10, 16'h0810, 16'h0410, 16'h0010};
  // host pin choice; the selector resynchronises it
  assign gpio_ref_sel = want_pin;
endmodule : drs_ref_src
`default_nettype wire

// [drs_ref_select_bench.sv]
// self-checking bench of the reference selector over apb
// assumes drs_ref_src on the monitor side and the map of drs_cfg.svh
`default_nettype none
`include "drs_cfg.svh"
module drs_ref_select_bench import drs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, holdover, free_run, irq, tw_history_valid;
  logic hist = 1'b0;
  logic [3:0] want = 4'h0;
  logic [1:0] pin = 2'h0;
  logic [3:0] ref_valid, ref_mux_sel, se_term_50, diff_term_100, bias_1v3;
  logic [3:0] ac_cap_bypass_switch, amp_det_en;
  logic [63:0] ref_phase;
  logic [1:0] gpio_ref_sel, active_ref;
  logic [15:0] phase_target, phase_buildout;
  // buffer code in the upper five bits, switches {se50,diff,bias,bypass,amp} below
  logic [9:0] codes [10] = '{10'h001, 10'h025, 10'h049, 10'h06d, 10'h091, 10'h0b5,
    10'h100, 10'h302, 10'h392, 10'h0c0};
  int n_errors = 0;
  int total_checks = 0;

  always #5 core_clk = ~core_clk;

  drs_ref_select DUT (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ref_valid, .ref_phase, .tw_history_valid, .gpio_ref_sel, .ref_mux_sel,
    .active_ref, .holdover, .free_run, .phase_target, .phase_buildout, .se_term_50,
    .diff_term_100, .bias_1v3, .ac_cap_bypass_switch, .amp_det_en, .irq);
  drs_ref_src src (.core_clk, .nrst, .want_valid(want), .want_hist(hist), .want_pin(pin),
    .ref_valid, .ref_phase, .tw_history_valid, .gpio_ref_sel);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; the first edge keeps a fresh setup off the previous release
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic go(input logic [3:0] v, input logic h);
    want <= v;
    hist <= h;
    repeat (6) @(posedge core_clk);
  endtask : go

  task automatic sel(input logic [1:0] a, input logic [3:0] m, input logic [1:0] hf);
    chk("select", {24'h0, a, m, hf}, {24'h0, active_ref, ref_mux_sel, holdover, free_run});
  endtask : sel

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    bus(1'b0, `DRS_A_PRIO, 32'h0);
    chk("prio", 32'h000000e4, q);
    foreach (codes[i]) begin
      bus(1'b1, `DRS_A_BUF, {12'h0, {4{codes[i][9:5]}}});
      repeat (2) @(posedge core_clk);
      chk("switch", {12'h0, {4{codes[i][4]}}, {4{codes[i][3]}}, {4{codes[i][2]}},
        {4{codes[i][1]}}, {4{codes[i][0]}}}, {12'h0, se_term_50, diff_term_100, bias_1v3,
        ac_cap_bypass_switch, amp_det_en});
    end
    bus(1'b0, `DRS_A_IST, 32'h0);
    chk("bad code", 32'h1, {31'h0, q[3]});
    bus(1'b1, `DRS_A_BUF, 32'h0);
    bus(1'b1, `DRS_A_ICLR, 32'h0000000f);
    bus(1'b1, `DRS_A_IEN, 32'h00000001);
    go(4'b0100, 1'b0);
    sel(2'd2, 4'b0100, 2'b00);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b0, `DRS_A_STAT, 32'h0);
    chk("stat", 32'h00000046, q);
    bus(1'b1, `DRS_A_ICLR, 32'h00000001);
    go(4'b0100, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b1, `DRS_A_IEN, 32'h0);
    go(4'b0110, 1'b0);
    sel(2'd1, 4'b0010, 2'b00);
    chk("irq", 32'h0, {31'h0, irq});
    chk("phase", {16'h0410, 16'h0000}, {phase_target, phase_buildout});
    bus(1'b1, `DRS_A_CTRL, 32'h00000001);
    go(4'b0111, 1'b0);
    sel(2'd1, 4'b0010, 2'b00);
    go(4'b0101, 1'b0);
    sel(2'd0, 4'b0001, 2'b00);
    bus(1'b1, `DRS_A_CTRL, 32'h00000020);
    go(4'b0010, 1'b0);
    chk("phase", {16'h0010, 16'h0400}, {phase_target, phase_buildout});
    repeat (20) @(posedge core_clk);
    chk("buildout", 32'h0400, {16'h0, phase_buildout});
    bus(1'b1, `DRS_A_SLEW, 32'h00000100);
    bus(1'b1, `DRS_A_CTRL, 32'h00000060);
    repeat (20) @(posedge core_clk);
    chk("phase", {16'h0410, 16'h0000}, {phase_target, phase_buildout});
    bus(1'b1, `DRS_A_SLEW, 32'h0fff0001);
    go(4'b0000, 1'b1);
    sel(2'd1, 4'b0000, 2'b10);
    bus(1'b1, `DRS_A_RATE, 32'h00010101);
    go(4'b1000, 1'b1);
    sel(2'd1, 4'b0000, 2'b10);
    go(4'b0001, 1'b1);
    sel(2'd0, 4'b0001, 2'b00);
    chk("buildout", 32'hfc00, {16'h0, phase_buildout});
    bus(1'b1, `DRS_A_RATE, 32'h01010101);
    bus(1'b1, `DRS_A_CTRL, 32'h0000000e);
    go(4'b1111, 1'b1);
    sel(2'd3, 4'b1000, 2'b00);
    go(4'b0111, 1'b1);
    sel(2'd0, 4'b0001, 2'b00);
    go(4'b0000, 1'b1);
    sel(2'd0, 4'b0000, 2'b10);
    go(4'b1000, 1'b1);
    sel(2'd3, 4'b1000, 2'b00);
    bus(1'b1, `DRS_A_CTRL, 32'h0000000f);
    go(4'b0111, 1'b0);
    sel(2'd3, 4'b0000, 2'b01);
    go(4'b0111, 1'b1);
    sel(2'd3, 4'b0000, 2'b10);
    bus(1'b0, `DRS_A_IST, 32'h0);
    chk("events", 32'h00000007, q);
    pin <= 2'd2;
    bus(1'b1, `DRS_A_CTRL, 32'h0000001e);
    go(4'b1111, 1'b1);
    sel(2'd2, 4'b0100, 2'b00);
    bus(1'b0, 12'h028, 32'h0);
    chk("unmapped", 32'h1, {q[31:1], e});
    finish_test();
  end

  // the tests need under 300 cycles; this cuts off a hang at 10000 cycles, well after that
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule : drs_ref_select_bench
`default_nettype wire
